// ---- logic/flash_host_consts.svh ----
// constants for the flash command host controller
// Functional notes
// - count N, then N+1 writes, then confirm
// - host issues only defined command codes
// - host leaves the buffer free check to software before continuing
// - host passes the buffer count to the device unchecked
// - software supplies byte select bit (address bit 0) in x8
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// software registers of the controller, word indices
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_DATA        4'h2
`define REG_COUNT       4'h3
`define REG_STATUS      4'h4
`define REG_RDATA       4'h5
`define REG_CFG         4'h6

// control register operation codes
`define OP_READ_ARRAY   4'h0
`define OP_READ_ID      4'h1
`define OP_READ_QUERY   4'h2
`define OP_READ_STATUS  4'h3
`define OP_CLR_STATUS   4'h4
`define OP_PROGRAM      4'h5
`define OP_BUF_WRITE    4'h6
`define OP_BLOCK_ERASE  4'h7
`define OP_SUSPEND      4'h8
`define OP_RESUME       4'h9
`define OP_STS_CONFIG   4'ha
`define OP_SET_LOCK     4'hb
`define OP_CLR_LOCKS    4'hc
`define OP_CHIP_ERASE   4'hd
`define OP_READ         4'he
`define OP_BUF_DATA     4'hf

// command codes on the low data byte
`define CMD_READ_ARRAY  8'hff
`define CMD_READ_ID     8'h90
`define CMD_READ_QUERY  8'h98
`define CMD_READ_STATUS 8'h70
`define CMD_CLR_STATUS  8'h50
`define CMD_BUF_WRITE   8'he8
`define CMD_PROGRAM     8'h40
`define CMD_PROGRAM_ALT 8'h10
`define CMD_ERASE       8'h20
`define CMD_SUSPEND     8'hb0
`define CMD_CONFIRM     8'hd0
`define CMD_STS_CONFIG  8'hb8
`define CMD_LOCK        8'h60
`define CMD_LOCK_SET    8'h01
`define CMD_CHIP_ERASE  8'h30

// query layout
`define QUERY_STRING_WORD 24'h000010
`define QUERY_STRING_BYTE 24'h000020

// bus timing: strobe low and recovery phases, ns and cycles at 4 ns
`define CLK_PERIOD_NS   4
`define T_STROBE_NS     100
`define T_RECOVER_NS    40
`define STROBE_CYCLES   ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYCLES  ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- logic/flash_host_pkg.sv ----
// types shared by the flash command host controller
package flash_host_pkg;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        rp_n;
		logic        wp;
		logic        byte_n;
		logic [23:0] addr;
	} flash_ctl_t;

	typedef struct packed {
		logic        is_write;
		logic [23:0] addr;
		logic [15:0] data;
	} bus_req_t;

	typedef enum logic [1:0] {
		CY_IDLE,
		CY_STROBE,
		CY_RECOVER
	} cycle_state_t;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_FIRST,
		SEQ_SECOND,
		SEQ_BUF_WAIT,
		SEQ_CONFIRM
	} seq_state_t;

endpackage

// ---- logic/flash_bus_cycle.sv ----
// one asynchronous flash bus cycle, read or write, timed in core clocks
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_bus_cycle (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire flash_host_pkg::bus_req_t  req,
	input  wire logic [15:0]               dq_in,
	output logic                           done,
	output logic [15:0]                    rd_data,
	output logic                           we_n,
	output logic                           oe_n,
	output logic                           ce_n,
	output logic [23:0]                    addr,
	output logic [15:0]                    dq_out,
	output logic                           dq_oe
);
	flash_host_pkg::cycle_state_t state_reg, state_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic        wr_reg, wr_next;
	logic [23:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic [15:0] rd_reg, rd_next;
	logic        done_reg, done_next;
	logic [15:0] dq_s1, dq_s2;

	// the done cycle counts as the idle gap, so a caller that still sees its old state cannot
	// start the same cycle a second time
	assign req_ready = (state_reg == flash_host_pkg::CY_IDLE) && !done_reg;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		wr_next    = wr_reg;
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		rd_next    = rd_reg;
		done_next  = 1'b0;
		case (state_reg)
			flash_host_pkg::CY_IDLE: begin
				if (req_valid && req_ready) begin
					wr_next    = req.is_write;
					addr_next  = req.addr;
					wdata_next = req.data;
					cnt_next   = 8'(`STROBE_CYCLES);
					state_next = flash_host_pkg::CY_STROBE;
				end
			end
			flash_host_pkg::CY_STROBE: begin
				if (cnt_reg == 8'h01) begin
					// data sampled from the synchronised bus at the end of the strobe
					rd_next    = dq_s2;
					cnt_next   = 8'(`RECOVER_CYCLES);
					state_next = flash_host_pkg::CY_RECOVER;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			flash_host_pkg::CY_RECOVER: begin
				if (cnt_reg == 8'h01) begin
					done_next  = 1'b1;
					state_next = flash_host_pkg::CY_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: state_next = flash_host_pkg::CY_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= flash_host_pkg::CY_IDLE;
			cnt_reg   <= 8'h00;
			wr_reg    <= 1'b0;
			addr_reg  <= 24'h000000;
			wdata_reg <= 16'h0000;
			rd_reg    <= 16'h0000;
			done_reg  <= 1'b0;
			dq_s1     <= 16'h0000;
			dq_s2     <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			wr_reg    <= wr_next;
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
			rd_reg    <= rd_next;
			done_reg  <= done_next;
			dq_s1     <= dq_in;
			dq_s2     <= dq_s1;
		end
	end

	// data stays driven through recovery so the device latches it on the we_n rise
	assign we_n    = !(wr_reg && state_reg == flash_host_pkg::CY_STROBE);
	assign oe_n    = !(!wr_reg && state_reg == flash_host_pkg::CY_STROBE);
	assign ce_n    = (state_reg == flash_host_pkg::CY_IDLE);
	assign dq_oe   = wr_reg && (state_reg != flash_host_pkg::CY_IDLE);
	assign dq_out  = wdata_reg;
	assign addr    = addr_reg;
	assign rd_data = rd_reg;
	assign done    = done_reg;
endmodule

// ---- logic/flash_cmd_host.sv ----
// host controller that issues command sequences to a parallel command-driven flash
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_cmd_host (
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [31:0]        reg_rdata,
	output flash_host_pkg::flash_ctl_t flash_ctl,
	input  wire logic [15:0]   dq_in,
	output logic [15:0]        dq_out,
	output logic               dq_oe
);
	flash_host_pkg::seq_state_t seq_reg, seq_next;
	logic [3:0]  op_reg, op_next;
	logic [23:0] target_reg, target_next;
	logic [15:0] data_reg, data_next;
	logic [7:0]  count_reg, count_next;
	logic [8:0]  left_reg, left_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        busy_reg, busy_next;
	logic        err_reg, err_next;
	logic        buf_pending_reg, buf_pending_next;
	logic        byte_mode_reg, byte_mode_next;
	logic        wp_reg, wp_next;
	logic        rp_n_reg, rp_n_next;
	logic [31:0] reg_rdata_reg, reg_rdata_next;

	logic        cyc_valid;
	logic        cyc_ready;
	logic        cyc_done;
	logic [15:0] cyc_rd;
	flash_host_pkg::bus_req_t cyc_req;
	logic        we_n_w, oe_n_w, ce_n_w;
	logic [23:0] addr_w;

	flash_bus_cycle u_cycle (
		.core_clk  (core_clk),
		.rst       (rst),
		.req_valid (cyc_valid),
		.req_ready (cyc_ready),
		.req       (cyc_req),
		.dq_in     (dq_in),
		.done      (cyc_done),
		.rd_data   (cyc_rd),
		.we_n      (we_n_w),
		.oe_n      (oe_n_w),
		.ce_n      (ce_n_w),
		.addr      (addr_w),
		.dq_out    (dq_out),
		.dq_oe     (dq_oe)
	);

	// first command code of each operation; only the low byte matters
	function automatic logic [7:0] first_code(input logic [3:0] op);
		case (op)
			`OP_READ_ARRAY:  first_code = `CMD_READ_ARRAY;
			`OP_READ_ID:     first_code = `CMD_READ_ID;
			`OP_READ_QUERY:  first_code = `CMD_READ_QUERY;
			`OP_READ_STATUS: first_code = `CMD_READ_STATUS;
			`OP_CLR_STATUS:  first_code = `CMD_CLR_STATUS;
			`OP_PROGRAM:     first_code = `CMD_PROGRAM;
			`OP_BUF_WRITE:   first_code = `CMD_BUF_WRITE;
			`OP_BLOCK_ERASE: first_code = `CMD_ERASE;
			`OP_SUSPEND:     first_code = `CMD_SUSPEND;
			`OP_RESUME:      first_code = `CMD_CONFIRM;
			`OP_STS_CONFIG:  first_code = `CMD_STS_CONFIG;
			`OP_SET_LOCK:    first_code = `CMD_LOCK;
			`OP_CLR_LOCKS:   first_code = `CMD_LOCK;
			`OP_CHIP_ERASE:  first_code = `CMD_CHIP_ERASE;
			default:         first_code = `CMD_READ_ARRAY; // never a reserved code
		endcase
	endfunction

	// second cycle data, or none for single-cycle commands
	function automatic logic [15:0] second_data(input logic [3:0] op, input logic [15:0] d,
		input logic [7:0] n);
		case (op)
			`OP_PROGRAM:     second_data = d;
			`OP_BUF_WRITE:   second_data = {8'h00, n};
			`OP_BLOCK_ERASE: second_data = {8'h00, `CMD_CONFIRM};
			`OP_CHIP_ERASE:  second_data = {8'h00, `CMD_CONFIRM};
			`OP_CLR_LOCKS:   second_data = {8'h00, `CMD_CONFIRM};
			`OP_SET_LOCK:    second_data = {8'h00, `CMD_LOCK_SET};
			default:         second_data = d;
		endcase
	endfunction

	function automatic logic two_cycle(input logic [3:0] op);
		two_cycle = (op == `OP_PROGRAM) || (op == `OP_BUF_WRITE) || (op == `OP_BLOCK_ERASE) ||
			(op == `OP_CHIP_ERASE) || (op == `OP_CLR_LOCKS) || (op == `OP_SET_LOCK) ||
			(op == `OP_STS_CONFIG);
	endfunction

	always_comb begin
		seq_next         = seq_reg;
		op_next          = op_reg;
		target_next      = target_reg;
		data_next        = data_reg;
		count_next       = count_reg;
		left_next        = left_reg;
		rdata_next       = rdata_reg;
		busy_next        = busy_reg;
		err_next         = err_reg;
		buf_pending_next = buf_pending_reg;
		byte_mode_next   = byte_mode_reg;
		wp_next          = wp_reg;
		rp_n_next        = rp_n_reg;
		reg_rdata_next   = 32'h00000000;
		cyc_valid        = 1'b0;
		cyc_req          = '{is_write: 1'b1, addr: target_reg, data: 16'h0000};

		if (reg_wr) begin
			case (reg_addr)
				`REG_ADDR:  target_next = reg_wdata[23:0];
				`REG_DATA:  data_next = reg_wdata[15:0];
				`REG_COUNT: count_next = reg_wdata[7:0];
				`REG_CFG: begin
					byte_mode_next = reg_wdata[0];
					wp_next        = reg_wdata[1]; // lock changes need protect high
					rp_n_next      = reg_wdata[2]; // power-down exit restores read array
				end
				`REG_CTRL: begin
					if (!busy_reg) begin // a command during the running one is dropped and sets err
						op_next   = reg_wdata[3:0];
						busy_next = 1'b1;
						err_next  = 1'b0;
						if (reg_wdata[3:0] == `OP_BUF_DATA) begin
							seq_next = buf_pending_reg ? flash_host_pkg::SEQ_BUF_WAIT
								: flash_host_pkg::SEQ_IDLE;
							busy_next = buf_pending_reg;
							err_next  = !buf_pending_reg;
						end else begin
							seq_next = flash_host_pkg::SEQ_FIRST;
						end
					end else begin
						err_next = 1'b1;
					end
				end
				default: ;
			endcase
		end

		case (seq_reg)
			flash_host_pkg::SEQ_IDLE: ;
			flash_host_pkg::SEQ_FIRST: begin
				cyc_valid = cyc_ready;
				if (op_reg == `OP_READ) begin
					cyc_req = '{is_write: 1'b0, addr: target_reg, data: 16'h0000};
				end else begin
					cyc_req = '{is_write: 1'b1, addr: target_reg,
						data: {8'h00, first_code(op_reg)}};
				end
				if (cyc_done) begin
					if (op_reg == `OP_READ) begin
						// words pass as driven
						rdata_next = cyc_rd;
						seq_next   = flash_host_pkg::SEQ_IDLE;
						busy_next  = 1'b0;
					end else if (two_cycle(op_reg)) begin
						seq_next = flash_host_pkg::SEQ_SECOND;
					end else begin
						seq_next  = flash_host_pkg::SEQ_IDLE;
						busy_next = 1'b0;
					end
				end
			end
			flash_host_pkg::SEQ_SECOND: begin
				cyc_valid = cyc_ready;
				cyc_req   = '{is_write: 1'b1, addr: target_reg,
					data: second_data(op_reg, data_reg, count_reg)};
				if (cyc_done) begin
					seq_next  = flash_host_pkg::SEQ_IDLE;
					busy_next = 1'b0;
					if (op_reg == `OP_BUF_WRITE) begin
						// software reads extended status before sending the words
						left_next        = {1'b0, count_reg} + 9'h001;
						buf_pending_next = 1'b1;
					end
				end
			end
			flash_host_pkg::SEQ_BUF_WAIT: begin
				cyc_valid = cyc_ready;
				cyc_req   = '{is_write: 1'b1, addr: target_reg, data: data_reg};
				if (cyc_done) begin
					left_next = left_reg - 9'h001;
					seq_next  = (left_reg == 9'h001) ? flash_host_pkg::SEQ_CONFIRM
						: flash_host_pkg::SEQ_IDLE;
					busy_next = (left_reg == 9'h001);
				end
			end
			flash_host_pkg::SEQ_CONFIRM: begin
				// confirm goes out after exactly count+1 data writes
				cyc_valid = cyc_ready;
				cyc_req   = '{is_write: 1'b1, addr: target_reg, data: {8'h00, `CMD_CONFIRM}};
				if (cyc_done) begin
					seq_next         = flash_host_pkg::SEQ_IDLE;
					busy_next        = 1'b0;
					buf_pending_next = 1'b0;
				end
			end
			default: seq_next = flash_host_pkg::SEQ_IDLE;
		endcase

		if (reg_rd) begin
			case (reg_addr)
				`REG_ADDR:   reg_rdata_next = {8'h00, target_reg};
				`REG_DATA:   reg_rdata_next = {16'h0000, data_reg};
				`REG_COUNT:  reg_rdata_next = {24'h000000, count_reg};
				`REG_STATUS: reg_rdata_next = {21'h000000, left_reg[7:0], err_reg,
					buf_pending_reg, busy_reg};
				`REG_RDATA:  reg_rdata_next = {16'h0000, rdata_reg};
				`REG_CFG:    reg_rdata_next = {29'h00000000, rp_n_reg, wp_reg, byte_mode_reg};
				`REG_CTRL:   reg_rdata_next = {28'h0000000, op_reg};
				default:     reg_rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			seq_reg         <= flash_host_pkg::SEQ_IDLE;
			op_reg          <= `OP_READ_ARRAY;
			target_reg      <= 24'h000000;
			data_reg        <= 16'h0000;
			count_reg       <= 8'h00;
			left_reg        <= 9'h000;
			rdata_reg       <= 16'h0000;
			busy_reg        <= 1'b0;
			err_reg         <= 1'b0;
			buf_pending_reg <= 1'b0;
			byte_mode_reg   <= 1'b0;
			wp_reg          <= 1'b0;
			rp_n_reg        <= 1'b0;
			reg_rdata_reg   <= 32'h00000000;
		end else begin
			seq_reg         <= seq_next;
			op_reg          <= op_next;
			target_reg      <= target_next;
			data_reg        <= data_next;
			count_reg       <= count_next;
			left_reg        <= left_next;
			rdata_reg       <= rdata_next;
			busy_reg        <= busy_next;
			err_reg         <= err_next;
			buf_pending_reg <= buf_pending_next;
			byte_mode_reg   <= byte_mode_next;
			wp_reg          <= wp_next;
			rp_n_reg        <= rp_n_next;
			reg_rdata_reg   <= reg_rdata_next;
		end
	end

	// in byte mode software supplies byte addresses, bit 0 included
	assign flash_ctl = '{ce_n: ce_n_w, oe_n: oe_n_w, we_n: we_n_w, rp_n: rp_n_reg,
		wp: wp_reg, byte_n: !byte_mode_reg, addr: addr_w};
	assign reg_rdata = reg_rdata_reg;
endmodule

// ---- test/flash_cmd_host_assertions.sv ----
// port checker for the flash command host
`timescale 1ns/1ps

module flash_cmd_host_checker (
	input wire logic                       core_clk,
	input wire logic                       rst,
	input wire logic [3:0]                 reg_addr,
	input wire logic [31:0]                reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [31:0]                reg_rdata,
	input wire flash_host_pkg::flash_ctl_t flash_ctl,
	input wire logic [15:0]                dq_out,
	input wire logic                       dq_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] low_reg;
	logic [7:0] low_next;
	// strobe is far longer than a repetition may unroll, so count it
	always_comb low_next = (rst || flash_ctl.we_n) ? 8'h00 : low_reg + 8'h01;
	always_ff @(posedge core_clk) low_reg <= low_next;
	sequence s_recover; (!flash_ctl.ce_n && dq_oe && $stable(dq_out)) [*8]; endsequence
	sequence s_read; (!flash_ctl.oe_n && !flash_ctl.ce_n && flash_ctl.we_n) [*8]; endsequence
	property p_reset;
		disable iff (1'b0) rst |=> flash_ctl.we_n && flash_ctl.oe_n && !flash_ctl.rp_n && !dq_oe;
	endproperty
	a_reset: assert property (p_reset) else $error("bus not idle in reset");
	property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	property p_cfg;
		reg_wr && reg_addr == 4'h6 |=> flash_ctl.wp == $past(reg_wdata[1])
			&& flash_ctl.rp_n == $past(reg_wdata[2]) && flash_ctl.byte_n == !$past(reg_wdata[0]);
	endproperty
	a_cfg: assert property (p_cfg) else $error("pin levels do not follow config");
	property p_strobe_len; $rose(flash_ctl.we_n) |-> low_reg == 8'h19; endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("write strobe length wrong");
	property p_write_drive; !flash_ctl.we_n |-> dq_oe && !flash_ctl.ce_n && flash_ctl.oe_n; endproperty
	a_write_drive: assert property (p_write_drive) else $error("write without drive");
	property p_write_hold;
		!flash_ctl.we_n && !$past(flash_ctl.we_n) |-> $stable(dq_out) && $stable(flash_ctl.addr);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("data moved in strobe");
	property p_recover; $rose(flash_ctl.we_n) |-> s_recover; endproperty
	a_recover: assert property (p_recover) else $error("data released too early");
	property p_read_cycle; $fell(flash_ctl.oe_n) |-> s_read; endproperty
	a_read_cycle: assert property (p_read_cycle) else $error("read cycle cut short");
	property p_no_contention; !flash_ctl.oe_n |-> !dq_oe; endproperty
	a_no_contention: assert property (p_no_contention) else $error("host drives in read");
endmodule

bind flash_cmd_host flash_cmd_host_checker chk (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .flash_ctl(flash_ctl), .dq_out(dq_out), .dq_oe(dq_oe));

// ---- test/flash_dev_model.sv ----
// behavioural model of the command-driven parallel flash
`timescale 1ns/1ps

module flash_dev_model #(
	parameter logic [15:0] MAKER = 16'h00a5, // arbitrary value
	parameter logic [15:0] PART  = 16'h005a  // arbitrary value
) (
	input wire flash_host_pkg::flash_ctl_t flash_ctl,
	input wire logic [15:0]                dq_out,
	output logic [15:0]                    dq_in
);
	logic [15:0] mem [256];
	logic [15:0] bdat [16];
	logic [7:0]  badr [16];
	logic [15:0] lock;
	logic [15:0] rdv;
	logic [15:0] last;
	logic [7:0]  pend;
	logic [7:0]  p;
	logic [7:0]  cmd;
	logic [7:0]  qa;
	logic [7:0]  q;
	logic [7:0]  a;
	logic [1:0]  mode;
	logic        wok;
	logic        drv;
	int          left;
	int          used;

	initial begin
		foreach (mem[i]) mem[i] = 16'hffff;
		lock = 16'h0;
		last = 16'h0;
	end
	always @(posedge flash_ctl.rp_n) begin
		mode = 2'd0;
		pend = 8'h00;
		left = 0;
	end
	always @(posedge flash_ctl.we_n) if (!flash_ctl.ce_n && flash_ctl.rp_n) begin
		a = flash_ctl.addr[7:0];
		cmd = dq_out[7:0];
		wok = !lock[a[7:4]] || flash_ctl.wp;
		p = pend;
		pend = 8'h00;
		if (p != 8'h00)
			mode = 2'd3;
		if (left > 0) begin
			badr[used] = a;
			bdat[used] = dq_out;
			used++;
			left--;
			pend = (left == 0) ? 8'hee : 8'h00;
		end else case (p)
			8'h40, 8'h10: if (wok) mem[a] = dq_out;
			8'he8: begin
				left = int'(cmd) + 1;
				used = 0;
			end
			// anything but confirm drops the buffered words
			8'hee: if (cmd == 8'hd0 && wok)
				for (int i = 0; i < used; i++) mem[badr[i]] = bdat[i];
			8'h20: if (cmd == 8'hd0 && wok)
				for (int i = 0; i < 16; i++) mem[{a[7:4], i[3:0]}] = 16'hffff;
			8'h30: if (cmd == 8'hd0) foreach (mem[i]) mem[i] = 16'hffff;
			8'h60: begin
				if (flash_ctl.wp && cmd == 8'h01) lock[a[7:4]] = 1'b1;
				if (flash_ctl.wp && cmd == 8'hd0) lock = 16'h0;
			end
			8'h00: case (cmd)
				8'hff: mode = 2'd0;
				8'h90: mode = 2'd1;
				8'h98: mode = 2'd2;
				8'h70: mode = 2'd3;
				8'h40, 8'h10, 8'he8, 8'h20, 8'h30, 8'h60, 8'hb8: pend = cmd;
				default: ;
			endcase
			default: ;
		endcase
	end
	always_comb begin
		qa = flash_ctl.byte_n ? flash_ctl.addr[7:0] : flash_ctl.addr[8:1];
		case (qa)
			8'h10: q = 8'h51;
			8'h11: q = 8'h52;
			8'h12: q = 8'h59;
			8'h13: q = 8'h01;
			default: q = 8'h00;
		endcase
		case (mode)
			2'd0: rdv = mem[flash_ctl.addr[7:0]];
			2'd1: rdv = flash_ctl.addr[7:0] == 8'h00 ? MAKER : flash_ctl.addr[7:0] == 8'h01 ? PART
				: {15'h0, flash_ctl.addr[3:0] == 4'h2 && lock[flash_ctl.addr[7:4]]};
			2'd2: rdv = {8'h00, q};
			default: rdv = 16'h0080;
		endcase
	end
	// a released bus shows the inverse of the last word driven
	always @(posedge flash_ctl.oe_n) last = ~rdv;
	assign drv = !flash_ctl.oe_n && !flash_ctl.ce_n && flash_ctl.rp_n;
	assign dq_in = drv ? {flash_ctl.byte_n ? rdv[15:8] : last[15:8], rdv[7:0]} : last;
endmodule

// ---- test/tb.sv ----
// self-checking bench for the flash command host
`timescale 1ns/1ps
`include "flash_host_consts.svh"
`define CHK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); bad_count++; end end

module tb;
	localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
	logic                       core_clk;
	logic                       rst;
	logic [3:0]                 reg_addr;
	logic [31:0]                reg_wdata;
	logic                       reg_wr;
	logic                       reg_rd;
	logic [31:0]                reg_rdata;
	flash_host_pkg::flash_ctl_t flash_ctl;
	logic [15:0]                dq_in;
	logic [15:0]                dq_out;
	logic                       dq_oe;
	logic [31:0]                rv;
	logic [15:0]                w;
	int                         bad_count;
	int                         tests_run;
	logic [7:0]                 qofs [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h05};
	logic [7:0]                 qexp [6] = '{8'h51, 8'h52, 8'h59, 8'h01, 8'h00, 8'h00};

	flash_cmd_host dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.flash_ctl(flash_ctl), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	flash_dev_model #(.MAKER(MAKER)) flash (.flash_ctl(flash_ctl), .dq_out(dq_out), .dq_in(dq_in));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// polls busy; a hung controller ends the run here
	task automatic run_op(input logic [3:0] op);
		reg_write(`REG_CTRL, {28'h0, op}); // ops map to defined codes only
		for (int n = 0; n < 300; n++) begin
			reg_read(`REG_STATUS, rv);
			if (rv[0] === 1'b0)
				return;
		end
		bad_count++;
		wrap_up();
	endtask

	task automatic flash_wr(input logic [3:0] op, input logic [23:0] a, input logic [15:0] d);
		reg_write(`REG_ADDR, {8'h0, a});
		reg_write(`REG_DATA, {16'h0, d});
		run_op(op);
	endtask

	task automatic flash_rd(input logic [23:0] a, output logic [15:0] d);
		reg_write(`REG_ADDR, {8'h0, a});
		run_op(`OP_READ);
		reg_read(`REG_RDATA, rv);
		d = rv[15:0];
	endtask

	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		#1 `CHK_EQ(flash_ctl.rp_n, 1'b0)
		reg_write(`REG_CFG, 32'h6);
		flash_wr(`OP_PROGRAM, 24'h3, 16'h1234);
		run_op(`OP_READ_ARRAY);
		flash_rd(24'h3, w);
		`CHK_EQ(w, 16'h1234)
		run_op(`OP_READ_QUERY);
		foreach (qofs[i]) begin
			flash_rd({16'h0, qofs[i]}, w);
			`CHK_EQ(w, {8'h00, qexp[i]})
		end
		// byte mode without a new command: query must stay selected
		reg_write(`REG_CFG, 32'h7);
		foreach (qofs[i]) for (int b = 0; b < 2; b++) begin
			flash_rd({15'h0, qofs[i], b[0]}, w);
			`CHK_EQ(w[7:0], qexp[i])
		end
		reg_write(`REG_CFG, 32'h4);
		flash_wr(`OP_SET_LOCK, 24'h12, 16'h0);
		run_op(`OP_READ_ID);
		flash_rd(24'h0, w);
		`CHK_EQ(w, MAKER)
		flash_rd(24'h12, w);
		`CHK_EQ(w, 16'h0)
		reg_write(`REG_CFG, 32'h6);
		flash_wr(`OP_SET_LOCK, 24'h12, 16'h0);
		flash_wr(`OP_SET_LOCK, 24'h22, 16'h0);
		run_op(`OP_READ_ID);
		flash_rd(24'h12, w);
		`CHK_EQ(w, 16'h1)
		reg_write(`REG_CFG, 32'h4);
		flash_wr(`OP_PROGRAM, 24'h13, 16'h0f0f);
		run_op(`OP_READ_ARRAY);
		flash_rd(24'h13, w);
		`CHK_EQ(w, 16'hffff)
		reg_write(`REG_CFG, 32'h6);
		run_op(`OP_CLR_LOCKS);
		run_op(`OP_READ_ID);
		flash_rd(24'h22, w);
		`CHK_EQ(w, 16'h0)
		// two words stay well inside one buffer
		reg_write(`REG_COUNT, 32'h1);
		flash_wr(`OP_BUF_WRITE, 24'h40, 16'h0);
		// status must show a free buffer before the words go out
		flash_rd(24'h40, w);
		`CHK_EQ(w[7], 1'b1)
		flash_wr(`OP_BUF_DATA, 24'h40, 16'haaaa);
		flash_wr(`OP_BUF_DATA, 24'h41, 16'h5555);
		run_op(`OP_READ_ARRAY);
		flash_rd(24'h41, w);
		`CHK_EQ(w, 16'h5555)
		flash_rd(24'h40, w);
		`CHK_EQ(w, 16'haaaa)
		flash_wr(`OP_BLOCK_ERASE, 24'h40, 16'h0);
		run_op(`OP_READ_ARRAY);
		flash_rd(24'h40, w);
		`CHK_EQ(w, 16'hffff)
		flash_rd(24'h3, w);
		`CHK_EQ(w, 16'h1234)
		flash_wr(`OP_CHIP_ERASE, 24'h0, 16'h0);
		run_op(`OP_READ_ARRAY);
		flash_rd(24'h3, w);
		`CHK_EQ(w, 16'hffff)
		reg_write(`REG_CTRL, {28'h0, `OP_BUF_DATA});
		reg_read(`REG_STATUS, rv);
		`CHK_EQ(rv[2], 1'b1)
		wrap_up();
	end
endmodule
